/* core/ppio_pkg.sv */
// constants shared by the port pin i/o control block
// assumes a 32-bit ahb-lite slave with byte offsets decoded from haddr[7:0]
package ppio_pkg;

  // ----------------------------------------------------------------
  // types and sizes
  // ----------------------------------------------------------------
  typedef logic [7:0] ppio_byte_type;

  localparam int NPORT = 7;

  localparam int IDX_P0  = 0;
  localparam int IDX_P1  = 1;
  localparam int IDX_P2  = 2;
  localparam int IDX_P6  = 3;
  localparam int IDX_P7  = 4;
  localparam int IDX_P12 = 5;
  localparam int IDX_P13 = 6;

  // ----------------------------------------------------------------
  // register map (byte offsets), index = port slot above
  // ----------------------------------------------------------------
  localparam logic [2:0] REGION_DATA = 3'h0;
  localparam logic [2:0] REGION_DIR  = 3'h1;
  localparam logic [2:0] REGION_PU   = 3'h2;
  localparam logic [2:0] REGION_MISC = 3'h3;

  localparam logic [2:0] MISC_ANALOG_DIGITAL_PIN_CONFIG = 3'h0;
  localparam logic [2:0] MISC_CSIM = 3'h1;
  localparam logic [2:0] MISC_CSIC = 3'h2;
  localparam logic [2:0] MISC_UCTL = 3'h3;

  // ----------------------------------------------------------------
  // per-port masks and reset values
  // ----------------------------------------------------------------
  localparam ppio_byte_type WIDTH_MASK [NPORT] = '{8'h7f, 8'hff, 8'hff, 8'h0f, 8'hff, 8'h1f, 8'h01};
  localparam ppio_byte_type DIR_WMASK  [NPORT] = '{8'h7f, 8'hff, 8'hff, 8'h0f, 8'hff, 8'h01, 8'h00};
  localparam ppio_byte_type DIR_RESET  [NPORT] = '{8'h7f, 8'hff, 8'hff, 8'h0f, 8'hff, 8'h1f, 8'h00};
  localparam ppio_byte_type PU_MASK    [NPORT] = '{8'h7f, 8'hff, 8'h00, 8'h00, 8'h04, 8'h01, 8'h00};
  localparam logic          OPEN_DRAIN [NPORT] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0};

  localparam ppio_byte_type LATCH_RESET    = 8'h00;
  localparam ppio_byte_type PU_RESET       = 8'h00;
  localparam ppio_byte_type ANALOG_DIGITAL_PIN_CONFIG_RESET     = 8'h00;
  localparam ppio_byte_type SERIAL_DEFAULT = 8'h00;
  localparam ppio_byte_type ALL_DIGITAL    = 8'hff;

  localparam int UCTL_TXINV_BIT = 0;
  localparam int P1_SCK_BIT     = 0;
  localparam int P1_SO_BIT      = 2;
  localparam int P1_TXD_BIT     = 3;

  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
  localparam logic       HRESP_OKAY    = 1'b0;

endpackage : ppio_pkg

/* core/ppio_port_bits.sv */
// one port's pin logic: drive, open-drain, pull-up gating and read-back
// assumes latch, direction and pull-up values come from flops in the top
`timescale 1ns/1ps
module ppio_port_bits #(
  parameter int         W          = 8,
  parameter logic [7:0] PU_ALLOWED = 8'hff,
  parameter logic       OD         = 1'b0
) (
  // register state
  input  wire logic [W-1:0] latch,
  input  wire logic [W-1:0] dir_in,
  input  wire logic [W-1:0] pu_sel,
  input  wire logic [W-1:0] digital,
  input  wire logic [W-1:0] drive_val,
  // pins
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] pin_out,
  output logic      [W-1:0] pin_oe,
  output logic      [W-1:0] pu_en,
  // read-back
  output logic      [W-1:0] rd_val
);

  logic [W-1:0] out_mode;

  // direction bit 1 selects input; analog bits never drive
  assign out_mode = ~dir_in & digital;

  // open-drain ports only ever pull low, a one releases the pin
  assign pin_oe  = OD ? (out_mode & ~drive_val) : out_mode;
  assign pin_out = OD ? '0 : drive_val;

  // pull-up only on input bits whose port has the option
  assign pu_en = pu_sel & PU_ALLOWED[W-1:0] & dir_in & digital;

  // digital output bits read the latch, digital input bits read the pin, analog bits read zero
  assign rd_val = (out_mode & latch) | (~dir_in & ~digital & '0) | (dir_in & digital & pin_in);

endmodule : ppio_port_bits

/* core/ppio_top.sv */
// general-purpose port pin i/o control, ahb-lite register slave
// assumes pins are synchronous to hclk and the single master does single word transfers
//
// Summary of operation
// - every port bit except port 12 bits 4:1 and the port 13 bit is set input or output by its direction register bit
// - port 0 latch is written by software and driven on output bits
// - port 0 input bits get a pull-up only when their option bit is set
// - reset puts all port 0 and port 1 bits in input mode
// - port 1 has eight bits with latch, direction and input pull-up control
// - port 2 has eight bits, direction, no pull-up, analog after reset
// - port 6 drivers only pull low and release for a one
// - port 7 drivers are all open-drain low-side with per-bit direction
// - port 7 pull-up exists only on bit 2
// - port 12 has bidirectional bit 0 plus four fixed input bits
// - port 12 pull-up exists only on bit 0
// - port 13 is one output-only bit, output after reset
// - port 1 bits 0 and 2 show the latch only while serial registers are default
// - port 1 bit 3 shows the latch only while uart level inversion is clear
// - port 2 bits act digitally only when the analog config selects digital
`timescale 1ns/1ps
module ppio_top (
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // alternate serial outputs sharing port 1
  input  wire logic        csi_sck_in,
  input  wire logic        csi_so_in,
  input  wire logic        uart_txd_in,
  // port 0
  input  wire logic [6:0]  p0_in,
  output logic      [6:0]  p0_out,
  output logic      [6:0]  p0_oe,
  output logic      [6:0]  p0_pullup,
  // port 1
  input  wire logic [7:0]  p1_in,
  output logic      [7:0]  p1_out,
  output logic      [7:0]  p1_oe,
  output logic      [7:0]  p1_pullup,
  // port 2
  input  wire logic [7:0]  p2_in,
  output logic      [7:0]  p2_out,
  output logic      [7:0]  p2_oe,
  output logic      [7:0]  p2_analog,
  // port 6, open-drain
  input  wire logic [3:0]  p6_in,
  output logic      [3:0]  p6_out,
  output logic      [3:0]  p6_oe,
  // port 7, open-drain
  input  wire logic [7:0]  p7_in,
  output logic      [7:0]  p7_out,
  output logic      [7:0]  p7_oe,
  output logic      [7:0]  p7_pullup,
  // port 12
  input  wire logic [4:0]  p12_in,
  output logic      [4:0]  p12_out,
  output logic      [4:0]  p12_oe,
  output logic      [4:0]  p12_pullup,
  // port 13, output only
  output logic             p13_out,
  output logic             p13_oe
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  ppio_pkg::ppio_byte_type latch_r [ppio_pkg::NPORT];
  ppio_pkg::ppio_byte_type latch_nxt [ppio_pkg::NPORT];
  ppio_pkg::ppio_byte_type dir_r [ppio_pkg::NPORT];
  ppio_pkg::ppio_byte_type dir_nxt [ppio_pkg::NPORT];
  ppio_pkg::ppio_byte_type pu_r [ppio_pkg::NPORT];
  ppio_pkg::ppio_byte_type pu_nxt [ppio_pkg::NPORT];
  ppio_pkg::ppio_byte_type analog_digital_pin_config_r;
  ppio_pkg::ppio_byte_type analog_digital_pin_config_nxt;
  ppio_pkg::ppio_byte_type csim_r;
  ppio_pkg::ppio_byte_type csim_nxt;
  ppio_pkg::ppio_byte_type csic_r;
  ppio_pkg::ppio_byte_type csic_nxt;
  ppio_pkg::ppio_byte_type uctl_r;
  ppio_pkg::ppio_byte_type uctl_nxt;
  logic                    wr_pend_r;
  logic                    wr_pend_nxt;
  logic [7:0]              wr_addr_r;
  logic [7:0]              wr_addr_nxt;
  logic [31:0]             hrdata_r;
  logic [31:0]             hrdata_nxt;

  // per-port wiring
  ppio_pkg::ppio_byte_type pin_in_a [ppio_pkg::NPORT];
  ppio_pkg::ppio_byte_type digital_a [ppio_pkg::NPORT];
  ppio_pkg::ppio_byte_type drive_a [ppio_pkg::NPORT];
  ppio_pkg::ppio_byte_type out_a [ppio_pkg::NPORT];
  ppio_pkg::ppio_byte_type oe_a [ppio_pkg::NPORT];
  ppio_pkg::ppio_byte_type pu_a [ppio_pkg::NPORT];
  ppio_pkg::ppio_byte_type rd_a [ppio_pkg::NPORT];

  logic       addr_ph;
  logic [2:0] ra_region;
  logic [2:0] ra_index;
  logic [2:0] wa_region;
  logic [2:0] wa_index;
  logic       serial_default;
  logic       tx_invert;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  // zero wait states; reads are sampled in the address phase, which is safe
  // because a single master never overlaps a write data phase with a read
  assign addr_ph   = hsel & hready & (htrans == ppio_pkg::HTRANS_NONSEQ);
  assign ra_region = haddr[7:5];
  assign ra_index  = haddr[4:2];
  assign wa_region = wr_addr_r[7:5];
  assign wa_index  = wr_addr_r[4:2];
  assign hreadyout = 1'b1;
  assign hresp     = ppio_pkg::HRESP_OKAY;
  assign hrdata    = hrdata_r;

  // ----------------------------------------------------------------
  // alternate function muxing on port 1
  // ----------------------------------------------------------------
  assign serial_default = (csim_r == ppio_pkg::SERIAL_DEFAULT) && (csic_r == ppio_pkg::SERIAL_DEFAULT);
  assign tx_invert      = uctl_r[ppio_pkg::UCTL_TXINV_BIT];

  always_comb
  begin
    for (int i = 0; i < ppio_pkg::NPORT; i++)
    begin
      drive_a[i]   = latch_r[i];
      digital_a[i] = ppio_pkg::ALL_DIGITAL;
    end
    digital_a[ppio_pkg::IDX_P2] = analog_digital_pin_config_r;
    if (!serial_default)
    begin
      drive_a[ppio_pkg::IDX_P1][ppio_pkg::P1_SCK_BIT] = csi_sck_in;
      drive_a[ppio_pkg::IDX_P1][ppio_pkg::P1_SO_BIT]  = csi_so_in;
    end
    if (tx_invert)
      drive_a[ppio_pkg::IDX_P1][ppio_pkg::P1_TXD_BIT] = ~uart_txd_in;
  end

  // ----------------------------------------------------------------
  // pin logic per port
  // ----------------------------------------------------------------
  assign pin_in_a[ppio_pkg::IDX_P0]  = {1'b0, p0_in};
  assign pin_in_a[ppio_pkg::IDX_P1]  = p1_in;
  assign pin_in_a[ppio_pkg::IDX_P2]  = p2_in;
  assign pin_in_a[ppio_pkg::IDX_P6]  = {4'h0, p6_in};
  assign pin_in_a[ppio_pkg::IDX_P7]  = p7_in;
  assign pin_in_a[ppio_pkg::IDX_P12] = {3'h0, p12_in};
  assign pin_in_a[ppio_pkg::IDX_P13] = 8'h00;

  for (genvar g = 0; g < ppio_pkg::NPORT; g++)
  begin : g_port
    ppio_port_bits #(
      .W          (8),
      .PU_ALLOWED (ppio_pkg::PU_MASK[g]),
      .OD         (ppio_pkg::OPEN_DRAIN[g])
    ) u_bits (
      .latch     (latch_r[g]),
      .dir_in    (dir_r[g]),
      .pu_sel    (pu_r[g]),
      .digital   (digital_a[g]),
      .drive_val (drive_a[g]),
      .pin_in    (pin_in_a[g] & ppio_pkg::WIDTH_MASK[g]),
      .pin_out   (out_a[g]),
      .pin_oe    (oe_a[g]),
      .pu_en     (pu_a[g]),
      .rd_val    (rd_a[g])
    );
  end

  assign p0_out     = out_a[ppio_pkg::IDX_P0][6:0];
  assign p0_oe      = oe_a[ppio_pkg::IDX_P0][6:0];
  assign p0_pullup  = pu_a[ppio_pkg::IDX_P0][6:0];
  assign p1_out     = out_a[ppio_pkg::IDX_P1];
  assign p1_oe      = oe_a[ppio_pkg::IDX_P1];
  assign p1_pullup  = pu_a[ppio_pkg::IDX_P1];
  assign p2_out     = out_a[ppio_pkg::IDX_P2];
  assign p2_oe      = oe_a[ppio_pkg::IDX_P2];
  assign p2_analog  = ~analog_digital_pin_config_r;
  assign p6_out     = out_a[ppio_pkg::IDX_P6][3:0];
  assign p6_oe      = oe_a[ppio_pkg::IDX_P6][3:0];
  assign p7_out     = out_a[ppio_pkg::IDX_P7];
  assign p7_oe      = oe_a[ppio_pkg::IDX_P7];
  assign p7_pullup  = pu_a[ppio_pkg::IDX_P7];
  assign p12_out    = out_a[ppio_pkg::IDX_P12][4:0];
  assign p12_oe     = oe_a[ppio_pkg::IDX_P12][4:0];
  assign p12_pullup = pu_a[ppio_pkg::IDX_P12][4:0];
  assign p13_out    = out_a[ppio_pkg::IDX_P13][0];
  assign p13_oe     = oe_a[ppio_pkg::IDX_P13][0];

  // ----------------------------------------------------------------
  // register next state
  // ----------------------------------------------------------------
  always_comb
  begin
    for (int i = 0; i < ppio_pkg::NPORT; i++)
    begin
      latch_nxt[i] = latch_r[i];
      dir_nxt[i]   = dir_r[i];
      pu_nxt[i]    = pu_r[i];
    end
    analog_digital_pin_config_nxt    = analog_digital_pin_config_r;
    csim_nxt    = csim_r;
    csic_nxt    = csic_r;
    uctl_nxt    = uctl_r;
    wr_pend_nxt = addr_ph & hwrite;
    wr_addr_nxt = addr_ph ? haddr[7:0] : wr_addr_r;
    hrdata_nxt  = hrdata_r;
    // write data phase
    if (wr_pend_r)
    begin
      if (wa_index < 3'(ppio_pkg::NPORT))
      begin
        unique case (wa_region)
          ppio_pkg::REGION_DATA: latch_nxt[wa_index] = hwdata[7:0] & ppio_pkg::WIDTH_MASK[wa_index];
          // fixed-direction bits keep their reset value whatever is written
          ppio_pkg::REGION_DIR:  dir_nxt[wa_index] = (hwdata[7:0] & ppio_pkg::DIR_WMASK[wa_index])
                                                   | (ppio_pkg::DIR_RESET[wa_index]
                                                   & ~ppio_pkg::DIR_WMASK[wa_index]);
          ppio_pkg::REGION_PU:   pu_nxt[wa_index] = hwdata[7:0] & ppio_pkg::PU_MASK[wa_index];
          default:               pu_nxt[wa_index] = pu_r[wa_index];
        endcase
      end
      if ((wa_region == ppio_pkg::REGION_MISC) && (wa_index == ppio_pkg::MISC_ANALOG_DIGITAL_PIN_CONFIG))
        analog_digital_pin_config_nxt = hwdata[7:0];
      if ((wa_region == ppio_pkg::REGION_MISC) && (wa_index == ppio_pkg::MISC_CSIM))
        csim_nxt = hwdata[7:0];
      if ((wa_region == ppio_pkg::REGION_MISC) && (wa_index == ppio_pkg::MISC_CSIC))
        csic_nxt = hwdata[7:0];
      if ((wa_region == ppio_pkg::REGION_MISC) && (wa_index == ppio_pkg::MISC_UCTL))
        uctl_nxt = hwdata[7:0];
    end
    // read address phase; unmapped reads return zero
    if (addr_ph && !hwrite)
    begin
      hrdata_nxt = 32'h0000_0000;
      if (ra_index < 3'(ppio_pkg::NPORT))
      begin
        unique case (ra_region)
          ppio_pkg::REGION_DATA: hrdata_nxt[7:0] = rd_a[ra_index];
          ppio_pkg::REGION_DIR:  hrdata_nxt[7:0] = dir_r[ra_index];
          ppio_pkg::REGION_PU:   hrdata_nxt[7:0] = pu_r[ra_index];
          default:               hrdata_nxt[7:0] = 8'h00;
        endcase
      end
      if (ra_region == ppio_pkg::REGION_MISC)
      begin
        unique case (ra_index)
          ppio_pkg::MISC_ANALOG_DIGITAL_PIN_CONFIG: hrdata_nxt[7:0] = analog_digital_pin_config_r;
          ppio_pkg::MISC_CSIM: hrdata_nxt[7:0] = csim_r;
          ppio_pkg::MISC_CSIC: hrdata_nxt[7:0] = csic_r;
          ppio_pkg::MISC_UCTL: hrdata_nxt[7:0] = uctl_r;
          default:             hrdata_nxt[7:0] = 8'h00;
        endcase
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      for (int i = 0; i < ppio_pkg::NPORT; i++)
      begin
        latch_r[i] <= ppio_pkg::LATCH_RESET;
        dir_r[i]   <= ppio_pkg::DIR_RESET[i];
        pu_r[i]    <= ppio_pkg::PU_RESET;
      end
      analog_digital_pin_config_r    <= ppio_pkg::ANALOG_DIGITAL_PIN_CONFIG_RESET;
      csim_r    <= ppio_pkg::SERIAL_DEFAULT;
      csic_r    <= ppio_pkg::SERIAL_DEFAULT;
      uctl_r    <= ppio_pkg::SERIAL_DEFAULT;
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
      hrdata_r  <= 32'h0000_0000;
    end
    else
    begin
      latch_r   <= latch_nxt;
      dir_r     <= dir_nxt;
      pu_r      <= pu_nxt;
      analog_digital_pin_config_r    <= analog_digital_pin_config_nxt;
      csim_r    <= csim_nxt;
      csic_r    <= csic_nxt;
      uctl_r    <= uctl_nxt;
      wr_pend_r <= wr_pend_nxt;
      wr_addr_r <= wr_addr_nxt;
      hrdata_r  <= hrdata_nxt;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic dir0_wr;
  assign dir0_wr = wr_pend_r && (wa_region == ppio_pkg::REGION_DIR) && (wa_index == 3'(ppio_pkg::IDX_P0));

  reset_inputs_a: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(hresetn) |-> (p0_oe == 7'h00) && (p1_oe == 8'h00))
    else $error("ports 0 and 1 not input after reset");

  p0_dir_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
    dir0_wr |=> (p0_oe == ~$past(hwdata[6:0])) && (p0_out == latch_r[0][6:0]))
    else $error("port 0 direction write not reflected on pins");

  pullup_gate_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ((p0_pullup & p0_oe) == 7'h00) && ((p1_pullup & p1_oe) == 8'h00))
    else $error("pull-up on a driving bit");

  p2_analog_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ((p2_oe & p2_analog) == 8'h00))
    else $error("analog port 2 bit driving");

  open_drain_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (p6_out == 4'h0) && (p7_out == 8'h00) && ((p6_oe & ~(~dir_r[3][3:0])) == 4'h0))
    else $error("open-drain port drove high or drove an input");

  p7_pullup_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (p7_pullup & 8'hfb) == 8'h00)
    else $error("port 7 pull-up outside bit 2");

  p12_fixed_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (p12_oe[4:1] == 4'h0) && (p12_pullup[4:1] == 4'h0))
    else $error("port 12 input-only bit driving or pulled up");

  p13_output_a: assert property (@(posedge hclk) disable iff (!hresetn)
    p13_oe && (p13_out == latch_r[6][0]))
    else $error("port 13 not driving its latch");

  serial_mux_a: assert property (@(posedge hclk) disable iff (!hresetn)
    serial_default |-> (p1_out[0] == latch_r[1][0]) && (p1_out[2] == latch_r[1][2]))
    else $error("port 1 bit 0 or 2 not showing latch in default serial state");

  txd_inv_a: assert property (@(posedge hclk) disable iff (!hresetn)
    tx_invert |-> (p1_out[3] == ~uart_txd_in))
    else $error("port 1 bit 3 not inverted uart output");

endmodule : ppio_top

/* test/ppio_pin_model.sv */
// external circuitry on one port: outside drivers, board pull-down, on-chip pull-up
// assumes the device splits each pin into level, drive enable and pull-up enable
`timescale 1ns/1ps
module ppio_pin_model #(
  parameter int W = 8
) (
  // device side
  input  wire logic [W-1:0] dev_out,
  input  wire logic [W-1:0] dev_oe,
  input  wire logic [W-1:0] dev_pu,
  // outside driver
  input  wire logic         ext_en,
  input  wire logic [W-1:0] ext_val,
  // resolved level
  output logic      [W-1:0] pin
);
  // ----------------------------------------------------------------
  // pin resolution
  // ----------------------------------------------------------------
  // outside driver backs off while the device drives, so no contention is modelled
  always_comb
  begin
    for (int i = 0; i < W; i++)
    begin
      if (dev_oe[i])
        pin[i] = dev_out[i];
      else if (ext_en)
        pin[i] = ext_val[i];
      else
        pin[i] = dev_pu[i]; // weak board pull-down loses to an enabled pull-up
    end
  end
endmodule : ppio_pin_model

/* test/test_port_pin_io_control.sv */
// self-checking bench for the port pin i/o control block
// assumes one ahb-lite master and a ppio_pin_model on every bidirectional port
`timescale 1ns/1ps
module test_port_pin_io_control;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [7:0]  board_pu;
  logic        csi_sck_in, csi_so_in, uart_txd_in, p13_out, p13_oe, ext_en;
  logic [6:0]  p0_in, p0_out, p0_oe, p0_pullup;
  logic [7:0]  p1_in, p1_out, p1_oe, p1_pullup, p2_in, p2_out, p2_oe, p2_analog;
  logic [3:0]  p6_in, p6_out, p6_oe;
  logic [7:0]  p7_in, p7_out, p7_oe, p7_pullup, ext_val, de, eoe, epin, q, dv;
  logic [4:0]  p12_in, p12_out, p12_oe, p12_pullup;
  logic [7:0]  oe_a [7];
  logic [7:0]  pin_a [7];
  logic [7:0]  pu_a [7];
  int          fail_count, num_checks;

  ppio_top u_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .csi_sck_in, .csi_so_in, .uart_txd_in,
    .p0_in, .p0_out, .p0_oe, .p0_pullup, .p1_in, .p1_out, .p1_oe, .p1_pullup, .p2_in, .p2_out,
    .p2_oe, .p2_analog, .p6_in, .p6_out, .p6_oe, .p7_in, .p7_out, .p7_oe, .p7_pullup, .p12_in,
    .p12_out, .p12_oe, .p12_pullup, .p13_out, .p13_oe);
  ppio_pin_model #(.W(7)) u_m0 (.dev_out(p0_out), .dev_oe(p0_oe), .dev_pu(p0_pullup), .ext_en,
    .ext_val(ext_val[6:0]), .pin(p0_in));
  ppio_pin_model #(.W(8)) u_m1 (.dev_out(p1_out), .dev_oe(p1_oe), .dev_pu(p1_pullup), .ext_en,
    .ext_val(ext_val), .pin(p1_in));
  ppio_pin_model #(.W(8)) u_m2 (.dev_out(p2_out), .dev_oe(p2_oe), .dev_pu(board_pu), .ext_en,
    .ext_val(ext_val), .pin(p2_in));
  ppio_pin_model #(.W(4)) u_m6 (.dev_out(p6_out), .dev_oe(p6_oe), .dev_pu(board_pu[3:0]), .ext_en,
    .ext_val(ext_val[3:0]), .pin(p6_in));
  ppio_pin_model #(.W(8)) u_m7 (.dev_out(p7_out), .dev_oe(p7_oe), .dev_pu(p7_pullup), .ext_en,
    .ext_val(ext_val), .pin(p7_in));
  ppio_pin_model #(.W(5)) u_m12 (.dev_out(p12_out), .dev_oe(p12_oe), .dev_pu(p12_pullup), .ext_en,
    .ext_val(ext_val[4:0]), .pin(p12_in));

  assign oe_a  = '{{1'b0, p0_oe}, p1_oe, p2_oe, {4'h0, p6_oe}, p7_oe, {3'h0, p12_oe}, {7'h0, p13_oe}};
  assign pin_a = '{{1'b0, p0_in}, p1_in, p2_in, {4'h0, p6_in}, p7_in, {3'h0, p12_in}, {7'h0, p13_out}};
  assign pu_a  = '{{1'b0, p0_pullup}, p1_pullup, 8'h00, 8'h00, p7_pullup, {3'h0, p12_pullup}, 8'h00};

  initial
  begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // holds each phase until hready is seen high; data taken at the data-phase edge
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= ppio_pkg::HTRANS_NONSEQ;
    hwrite <= wr;
    @(posedge hclk);
    while (hreadyout !== 1'b1)
      @(posedge hclk);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {24'h0, d};
    @(posedge hclk);
    while (hreadyout !== 1'b1)
      @(posedge hclk);
    q = hrdata[7:0];
    #1;
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    xfer(1'b1, a, d);
  endtask : wr

  task automatic rd(input string what, input logic [7:0] a, input logic [7:0] exp);
    xfer(1'b0, a, 8'h00);
    chk(what, q, exp);
  endtask : rd

  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : end_sim

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial
  begin
    {hresetn, hsel, haddr, htrans, hwrite, hwdata} = '0;
    hsize = 3'b010;
    board_pu = 8'h00;
    {csi_sck_in, csi_so_in, uart_txd_in} = 3'b000;
    ext_en = 1'b1;
    ext_val = 8'h3c;
    fail_count = 0;
    num_checks = 0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    #1;
    for (int i = 0; i < 7; i++)
    begin
      chk("oe after reset", oe_a[i], (i == 6) ? 8'h01 : 8'h00);
      chk("pull-up after reset", pu_a[i], 8'h00);
      rd("direction after reset", 8'h20 + 8'(4 * i), ppio_pkg::DIR_RESET[i]);
    end
    chk("analog after reset", p2_analog, 8'hff);
    rd("analog port read", 8'h08, 8'h00);
    wr(8'h60, 8'hff);
    chk("analog after config", p2_analog, 8'h00);
    // mixed directions, latch and pull-ups on every port; fixed bits must keep reset values
    // open-drain ports get zeros on some output bits so the low-side driver is exercised
    for (int i = 0; i < 7; i++)
    begin
      dv   = ppio_pkg::OPEN_DRAIN[i] ? 8'hc3 : 8'ha5;
      wr(8'(4 * i), dv);
      wr(8'h20 + 8'(4 * i), 8'h5a);
      wr(8'h40 + 8'(4 * i), 8'hff);
      de   = (8'h5a & ppio_pkg::DIR_WMASK[i]) | (ppio_pkg::DIR_RESET[i] & ~ppio_pkg::DIR_WMASK[i]);
      eoe  = ~de & ppio_pkg::WIDTH_MASK[i] & (ppio_pkg::OPEN_DRAIN[i] ? ~dv : 8'hff);
      epin = ((eoe & (ppio_pkg::OPEN_DRAIN[i] ? 8'h00 : dv)) | (~eoe & 8'h3c)) & ppio_pkg::WIDTH_MASK[i];
      chk("output enable", oe_a[i], eoe);
      chk("pin level", pin_a[i] & ppio_pkg::WIDTH_MASK[i], epin);
      chk("pull-up", pu_a[i], ppio_pkg::PU_MASK[i] & de);
      rd("port read", 8'(4 * i), ((dv & ~de) | (epin & de)) & ppio_pkg::WIDTH_MASK[i]);
      rd("direction read", 8'h20 + 8'(4 * i), de & ppio_pkg::WIDTH_MASK[i]);
      rd("pull-up read", 8'h40 + 8'(4 * i), ppio_pkg::PU_MASK[i]);
    end
    // released inputs now float to the on-chip pull-up or the board pull-down
    @(posedge hclk);
    ext_en <= 1'b0;
    wr(8'h40, 8'h0f);
    rd("pulled input read", 8'h00, 8'h2f);
    ext_en <= 1'b1;
    wr(8'h24, 8'h00);
    for (int a = 8'h64; a <= 8'h68; a += 4)
    begin
      wr(8'(a), 8'h01);
      chk("serial shared bits", {6'h0, p1_out[2], p1_out[0]}, 8'h00);
      wr(8'(a), 8'h00);
      chk("latch shared bits", {6'h0, p1_out[2], p1_out[0]}, 8'h03);
    end
    wr(8'h6c, 8'h01);
    chk("inverted tx bit", {7'h0, p1_out[3]}, 8'h01);
    wr(8'h6c, 8'h00);
    chk("latch tx bit", {7'h0, p1_out[3]}, 8'h00);
    rd("unmapped read", 8'h7c, 8'h00);
    wr(8'h1c, 8'hff);
    rd("unmapped after write", 8'h1c, 8'h00);
    // reset in mid-run must drop the port 0 and port 1 drivers back to input
    @(posedge hclk);
    hresetn <= 1'b0;
    @(posedge hclk);
    #1;
    chk("port 0 oe in reset", oe_a[0], 8'h00);
    chk("port 1 oe in reset", oe_a[1], 8'h00);
    @(posedge hclk);
    hresetn <= 1'b1;
    rd("port 0 direction after second reset", 8'h20, 8'h7f);
    rd("port 1 direction after second reset", 8'h24, 8'hff);
    end_sim();
  end

  initial
  begin
    repeat (5000) @(posedge hclk);
    fail_count++;
    end_sim();
  end
endmodule : test_port_pin_io_control
